// [sfcs_link.sv]
// Purpose: shared constants and types, plus the serial front end that runs on the link clock
// Assumes: sck runs only while cs_n is low; the link reset input comes from a flop in the mclk domain
// Notes:   the header below lists the functional notes of the sequencer
`timescale 1ns/100ps

package sfcs_pkg;
  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS         = 100;
  localparam int ERASE_PROGRAM_TIME_US = 20000; // longest time, rounds down
  localparam int PAGE_TRANSFER_TIME_US = 300;   // longest time, rounds down
  localparam int ERASE_PROGRAM_CYCLES  = (ERASE_PROGRAM_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int PAGE_TRANSFER_CYCLES  = (PAGE_TRANSFER_TIME_US * 1000) / CLK_PERIOD_NS;

  // ==========================================================================
  // geometry and framing
  localparam int         BUF_BYTES     = 264;
  localparam logic [8:0] BUF_LAST      = 9'h107;   // position 263
  localparam logic [5:0] CNT_OP_LAST   = 6'h07;    // edge that completes the opcode
  localparam logic [5:0] CNT_HDR_LAST  = 6'h1f;    // edge that completes the header
  localparam logic [5:0] CNT_DATA_BASE = 6'h20;
  localparam logic [5:0] CNT_DATA_TOP  = 6'h27;
  localparam logic [5:0] CNT_STAT_FROM = 6'h08;
  localparam logic [3:0] WP_PAGE_HI    = 4'h0;     // page[11:8] zero means page below 256
  localparam int         ST_READY_BIT  = 7;
  localparam int         ST_COMP_BIT   = 6;
  localparam logic [3:0] DENSITY_DFLT  = 4'h3;     // arbitrary value
  localparam logic       SPI_MODE3     = 1'b1;

  // ==========================================================================
  // opcodes
  localparam logic [7:0] OP_PTB_1   = 8'h82;
  localparam logic [7:0] OP_PTB_2   = 8'h85;
  localparam logic [7:0] OP_BWR_1   = 8'h84;
  localparam logic [7:0] OP_BWR_2   = 8'h87;
  localparam logic [7:0] OP_BPE_1   = 8'h83;
  localparam logic [7:0] OP_BPE_2   = 8'h86;
  localparam logic [7:0] OP_BPN_1   = 8'h88;
  localparam logic [7:0] OP_BPN_2   = 8'h89;
  localparam logic [7:0] OP_PG_ER   = 8'h81;
  localparam logic [7:0] OP_BLK_ER  = 8'h50;
  localparam logic [7:0] OP_XFR_1   = 8'h53;
  localparam logic [7:0] OP_XFR_2   = 8'h55;
  localparam logic [7:0] OP_CMP_1   = 8'h60;
  localparam logic [7:0] OP_CMP_2   = 8'h61;
  localparam logic [7:0] OP_RW_1    = 8'h58;
  localparam logic [7:0] OP_RW_2    = 8'h59;
  localparam logic [7:0] OP_STAT_A  = 8'h57;
  localparam logic [7:0] OP_STAT_B  = 8'hd7;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    AOP_NONE, AOP_XFR, AOP_CMP, AOP_PROG_ERASE, AOP_PROG, AOP_PAGE_ERASE, AOP_BLOCK_ERASE
  } sfcs_aop_t;

  typedef enum logic [1:0] {SQ_IDLE, SQ_RW_XFR, SQ_RUN} sfcs_sq_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [2:0]  rsvd;
    logic [11:0] page_addr;
    logic [8:0]  buffer_byte_addr;
  } sfcs_hdr_t;

  typedef struct packed {
    logic       buf_sel;
    logic [8:0] addr;
    logic [7:0] data;
  } sfcs_bwr_t;

  typedef struct packed {
    sfcs_aop_t   op;
    logic        buf_sel;
    logic [11:0] page_addr;
  } sfcs_areq_t;

  // ==========================================================================
  // decode helpers
  function automatic logic sfcs_buf_of(input logic [7:0] op);
    sfcs_buf_of = (op == OP_PTB_2) || (op == OP_BWR_2) || (op == OP_BPE_2) || (op == OP_BPN_2) ||
                  (op == OP_XFR_2) || (op == OP_CMP_2) || (op == OP_RW_2);
  endfunction

  function automatic logic sfcs_is_bufwr(input logic [7:0] op);
    sfcs_is_bufwr = (op == OP_PTB_1) || (op == OP_PTB_2) || (op == OP_BWR_1) || (op == OP_BWR_2);
  endfunction

  // buffer position after a, wrapping past the last byte
  function automatic logic [8:0] sfcs_wrap(input logic [8:0] a);
    sfcs_wrap = (a >= BUF_LAST) ? 9'h000 : a + 9'h001;
  endfunction
endpackage

// ============================================================================
// serial front end on sck
module sfcs_link
  import sfcs_pkg::*;
#(
  parameter logic [3:0] DENSITY = DENSITY_DFLT  // arbitrary value
) (
  input  wire logic      sck,
  input  wire logic      cs_n,
  input  wire logic      si,
  input  wire logic      lnk_rst,
  input  wire logic      stat_ready,
  input  wire logic      stat_comp,
  output logic           so,
  output logic           so_oe,
  output sfcs_hdr_t      hdr,
  output logic           hdr_ok,
  output sfcs_bwr_t      bwr,
  output logic           bwr_tgl
);
  logic [5:0]  cnt_q;
  logic [30:0] sr_q;
  logic [7:0]  op_q;
  sfcs_hdr_t   hdr_q;
  logic        hdr_ok_q;
  logic [8:0]  ptr_q;
  sfcs_bwr_t   bwr_q;
  logic        tgl_q;
  logic [1:0]  stat_s1_q;
  logic [1:0]  stat_s2_q;
  logic        so_q;
  logic        so_oe_q;
  logic        byte_done;
  logic [31:0] hdr_in;
  logic [7:0]  stat_byte;

  assign hdr_in    = {sr_q, si};
  assign byte_done = cnt_q[5] && (cnt_q[2:0] == 3'h7);
  assign stat_byte = {stat_s2_q[1], stat_s2_q[0], DENSITY, 2'b00};

  // bit counter; cs_n high clears it, so every frame starts fresh
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      cnt_q <= 6'h00;
    end else if (cnt_q == CNT_DATA_TOP) begin
      cnt_q <= CNT_DATA_BASE;
    end else begin
      cnt_q <= cnt_q + 6'h01;
    end
  end

  // si sampled only on rising sck inside a frame
  always_ff @(posedge sck) begin
    sr_q <= hdr_in[30:0];
    if (cnt_q == CNT_OP_LAST) begin
      op_q <= hdr_in[7:0];
    end
    if (cnt_q == CNT_HDR_LAST) begin
      hdr_q <= hdr_in;
    end
  end

  // header-valid flag survives cs_n rise so the mclk side can act on it
  always_ff @(posedge sck or posedge lnk_rst) begin
    if (lnk_rst) begin
      hdr_ok_q <= 1'b0;
    end else if (cnt_q == 6'h00) begin
      hdr_ok_q <= 1'b0;
    end else if (cnt_q == CNT_HDR_LAST) begin
      hdr_ok_q <= 1'b1;
    end
  end

  // data bytes go to successive buffer positions with wrap
  always_ff @(posedge sck) begin
    if (cnt_q == CNT_HDR_LAST) begin
      ptr_q <= (hdr_in[8:0] > BUF_LAST) ? 9'h000 : hdr_in[8:0];
    end else if (byte_done && sfcs_is_bufwr(op_q)) begin
      bwr_q <= '{buf_sel: sfcs_buf_of(op_q), addr: ptr_q, data: hdr_in[7:0]};
      ptr_q <= sfcs_wrap(ptr_q);
    end
  end

  // toggle per byte; not cleared by cs_n so the last byte is never lost
  always_ff @(posedge sck or posedge lnk_rst) begin
    if (lnk_rst) begin
      tgl_q <= 1'b0;
    end else if (byte_done && sfcs_is_bufwr(op_q)) begin
      tgl_q <= ~tgl_q;
    end
  end

  // status bits from mclk domain, two flops each
  always_ff @(posedge sck) begin
    stat_s1_q <= {stat_ready, stat_comp};
    stat_s2_q <= stat_s1_q;
  end

  // so changes on falling sck, released while deselected
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      so_q    <= 1'b0;
      so_oe_q <= 1'b0;
    end else if (((op_q == OP_STAT_A) || (op_q == OP_STAT_B)) && (cnt_q >= CNT_STAT_FROM)) begin
      so_oe_q <= 1'b1;
      so_q    <= stat_byte[~cnt_q[2:0]];
    end
  end

  assign so      = so_q;
  assign so_oe   = so_oe_q;
  assign hdr     = hdr_q;
  assign hdr_ok  = hdr_ok_q;
  assign bwr     = bwr_q;
  assign bwr_tgl = tgl_q;
endmodule

// [sfcs_seq.sv]
// Purpose: array command sequencer with self-timed busy, write protect and buffer write port
// Assumes: cs_n stays high at least three mclk periods between frames
// Notes:   array and buffer storage live outside; this block issues requests and writes
`timescale 1ns/100ps

module sfcs_seq
  import sfcs_pkg::*;
#(
  parameter int         EP_CYCLES  = ERASE_PROGRAM_CYCLES,
  parameter int         XFR_CYCLES = PAGE_TRANSFER_CYCLES,
  parameter logic [3:0] DENSITY    = DENSITY_DFLT       // arbitrary value
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        si,
  input  wire logic        wp_n,
  input  wire logic        arr_cmp_diff,
  output logic             so,
  output logic             so_oe,
  output logic             rdy_busy,
  output logic             rdy_busy_oe,
  output logic [7:0]       status_byte,
  output logic             spi_mode3,
  output logic             arr_start,
  output sfcs_areq_t       arr_req,
  output logic             buf_wr,
  output sfcs_bwr_t        buf_wr_info
);
  localparam int CNT_W = $clog2(EP_CYCLES + 1);

  // ==========================================================================
  // declarations
  logic [3:0]  por_cnt_q = 4'h0;
  logic        rst_q;
  logic        cs_s1_q, cs_s2_q, cs_s3_q;
  logic        sck_s1_q, sck_s2_q;
  logic        sck_idle_q;
  logic        wp_s1_q, wp_s2_q;
  logic        tgl_s1_q, tgl_s2_q, tgl_seen_q;
  logic        ok_s1_q, ok_s2_q;
  logic        cs_rise, cs_fall;
  sfcs_hdr_t   hdr;
  logic        hdr_ok;
  sfcs_bwr_t   bwr;
  logic        bwr_tgl;
  sfcs_sq_t    state_q;
  logic [CNT_W-1:0] cnt_q;
  sfcs_aop_t   cur_op_q;
  logic        cur_buf_q;
  logic        uses_buf_q;
  logic        busy_q;
  logic        comp_q;
  logic [7:0]  status_q;
  logic        mode3_q;
  logic        arr_start_q;
  sfcs_areq_t  arr_req_q;
  logic        buf_wr_q;
  sfcs_bwr_t   buf_wr_info_q;
  logic        rdy_busy_q;
  sfcs_aop_t   dec_op;
  logic        dec_rewrite;
  logic        dec_modify;
  logic        dec_uses_buf;
  logic [11:0] dec_page;
  logic        dec_protected;
  logic        start_ok;
  logic        bwr_evt;

  // ==========================================================================
  // serial front end
  sfcs_link #(
    .DENSITY (DENSITY)
  ) u_link (
    .sck        (sck),
    .cs_n       (cs_n),
    .si         (si),
    .lnk_rst    (rst_q),
    .stat_ready (status_q[ST_READY_BIT]),
    .stat_comp  (status_q[ST_COMP_BIT]),
    .so         (so),
    .so_oe      (so_oe),
    .hdr        (hdr),
    .hdr_ok     (hdr_ok),
    .bwr        (bwr),
    .bwr_tgl    (bwr_tgl)
  );

  // ==========================================================================
  // reset: power-on counter or rstn pin, both synchronous
  // power-on count lets the part start right even if rstn is never pulsed
  always_ff @(posedge mclk) begin
    if (por_cnt_q != 4'hf) begin
      por_cnt_q <= por_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    rst_q <= ~rstn || (por_cnt_q != 4'hf);
  end

  // ==========================================================================
  // pin synchronisers, two flops before any logic except the cs_s1_q gate of the idle sck tracking
  always_ff @(posedge mclk) begin
    cs_s1_q  <= cs_n;
    cs_s2_q  <= cs_s1_q;
    cs_s3_q  <= cs_s2_q;
    sck_s1_q <= sck;
    sck_s2_q <= sck_s1_q;
    wp_s1_q  <= wp_n;
    wp_s2_q  <= wp_s1_q;
    tgl_s1_q <= bwr_tgl;
    tgl_s2_q <= tgl_s1_q;
    ok_s1_q  <= hdr_ok;
    ok_s2_q  <= ok_s1_q;
  end

  assign cs_rise = cs_s2_q && !cs_s3_q;
  assign cs_fall = !cs_s2_q && cs_s3_q;

  // ==========================================================================
  // idle sck level, tracked only while cs_n was still high a cycle earlier;
  // sck may move less than one mclk after cs_n falls, so a late sample lies
  always_ff @(posedge mclk) begin
    if (rst_q) begin
      sck_idle_q <= SPI_MODE3;
    end else if (cs_s1_q) begin
      sck_idle_q <= sck_s2_q;
    end
  end

  // clock mode picked from sck idle level at each frame start
  always_ff @(posedge mclk) begin
    if (rst_q) begin
      mode3_q <= SPI_MODE3;
    end else if (cs_fall) begin
      mode3_q <= sck_idle_q;
    end
  end

  // ==========================================================================
  // command decode; header is frozen once cs_n is high
  always_comb begin
    dec_op       = AOP_NONE;
    dec_rewrite  = 1'b0;
    dec_modify   = 1'b1;
    dec_uses_buf = 1'b1;
    dec_page     = hdr.page_addr;
    unique case (hdr.opcode)
      OP_PTB_1, OP_PTB_2, OP_BPE_1, OP_BPE_2: begin
        dec_op = AOP_PROG_ERASE;
      end
      OP_BPN_1, OP_BPN_2: begin
        dec_op = AOP_PROG;
      end
      OP_PG_ER: begin
        dec_op       = AOP_PAGE_ERASE;
        dec_uses_buf = 1'b0;
      end
      OP_BLK_ER: begin
        dec_op       = AOP_BLOCK_ERASE;
        dec_uses_buf = 1'b0;
        dec_page     = {hdr.page_addr[11:3], 3'h0};
      end
      OP_XFR_1, OP_XFR_2: begin
        dec_op     = AOP_XFR;
        dec_modify = 1'b0;
      end
      OP_CMP_1, OP_CMP_2: begin
        dec_op     = AOP_CMP;
        dec_modify = 1'b0;
      end
      OP_RW_1, OP_RW_2: begin
        dec_op      = AOP_XFR;
        dec_rewrite = 1'b1;
      end
      default: begin
        dec_modify   = 1'b0;
        dec_uses_buf = 1'b0;
      end
    endcase
  end

  // protected region: any page below 256 while wp_n is low
  assign dec_protected = dec_modify && !wp_s2_q && (dec_page[11:8] == WP_PAGE_HI);

  // a new array command is taken only when idle, later ones are dropped
  assign start_ok = cs_rise && ok_s2_q && (state_q == SQ_IDLE) &&
                    (dec_op != AOP_NONE) && !dec_protected;

  // ==========================================================================
  // self-timed sequencer; busy lasts exactly the configured count
  always_ff @(posedge mclk) begin
    if (rst_q) begin
      state_q <= SQ_IDLE;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        SQ_IDLE: begin
          if (start_ok) begin
            if (dec_rewrite) begin
              state_q <= SQ_RW_XFR;
              cnt_q   <= CNT_W'(XFR_CYCLES - 1);
            end else begin
              state_q <= SQ_RUN;
              cnt_q   <= ((dec_op == AOP_XFR) || (dec_op == AOP_CMP)) ?
                         CNT_W'(XFR_CYCLES - 1) : CNT_W'(EP_CYCLES - 1);
            end
          end
        end
        SQ_RW_XFR: begin
          if (cnt_q == '0) begin
            state_q <= SQ_RUN;
            cnt_q   <= CNT_W'(EP_CYCLES - XFR_CYCLES - 1);
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        SQ_RUN: begin
          if (cnt_q == '0) begin
            state_q <= SQ_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
      endcase
    end
  end

  // busy flag and buffer in use, aligned with the state
  always_ff @(posedge mclk) begin
    if (rst_q) begin
      busy_q     <= 1'b0;
      cur_op_q   <= AOP_NONE;
      cur_buf_q  <= 1'b0;
      uses_buf_q <= 1'b0;
    end else if (start_ok) begin
      busy_q     <= 1'b1;
      cur_op_q   <= dec_op;
      cur_buf_q  <= sfcs_buf_of(hdr.opcode);
      uses_buf_q <= dec_uses_buf;
    end else if (state_q == SQ_RW_XFR && cnt_q == '0) begin
      cur_op_q <= AOP_PROG_ERASE;
    end else if (state_q == SQ_RUN && cnt_q == '0) begin
      busy_q     <= 1'b0;
      cur_op_q   <= AOP_NONE;
      uses_buf_q <= 1'b0;
    end
  end

  // ==========================================================================
  // requests to the array macro, one-cycle start pulses
  always_ff @(posedge mclk) begin
    if (rst_q) begin
      arr_start_q <= 1'b0;
      arr_req_q   <= '{op: AOP_NONE, buf_sel: 1'b0, page_addr: 12'h000};
    end else if (start_ok) begin
      arr_start_q <= 1'b1;
      arr_req_q   <= '{op: dec_op, buf_sel: sfcs_buf_of(hdr.opcode), page_addr: dec_page};
    end else if (state_q == SQ_RW_XFR && cnt_q == '0) begin
      arr_start_q <= 1'b1;
      arr_req_q   <= '{op: AOP_PROG_ERASE, buf_sel: cur_buf_q, page_addr: arr_req_q.page_addr};
    end else begin
      arr_start_q <= 1'b0;
    end
  end

  // compare outcome taken in the last busy cycle
  always_ff @(posedge mclk) begin
    if (rst_q) begin
      comp_q <= 1'b0;
    end else if (state_q == SQ_RUN && cnt_q == '0 && cur_op_q == AOP_CMP) begin
      comp_q <= arr_cmp_diff;
    end
  end

  // ==========================================================================
  // status byte and open-drain ready/busy; status trails busy by one cycle
  always_ff @(posedge mclk) begin
    if (rst_q) begin
      status_q   <= {1'b1, 1'b0, DENSITY, 2'b00};
      rdy_busy_q <= 1'b0;
    end else begin
      status_q   <= {~busy_q, comp_q, DENSITY, 2'b00};
      rdy_busy_q <= 1'b0;                                // driven level is always low
    end
  end

  // ==========================================================================
  // buffer writes from the link; the busy buffer is blocked, the other is free
  assign bwr_evt = (tgl_s2_q != tgl_seen_q);

  always_ff @(posedge mclk) begin
    if (rst_q) begin
      tgl_seen_q    <= 1'b0;
      buf_wr_q      <= 1'b0;
      buf_wr_info_q <= '{buf_sel: 1'b0, addr: 9'h000, data: 8'h00};
    end else begin
      tgl_seen_q <= tgl_s2_q;
      buf_wr_q   <= bwr_evt && !(busy_q && uses_buf_q && (bwr.buf_sel == cur_buf_q));
      if (bwr_evt) begin
        buf_wr_info_q <= bwr;
      end
    end
  end

  assign rdy_busy    = rdy_busy_q;
  assign rdy_busy_oe = busy_q;
  assign status_byte = status_q;
  assign spi_mode3   = mode3_q;
  assign arr_start   = arr_start_q;
  assign arr_req     = arr_req_q;
  assign buf_wr      = buf_wr_q;
  assign buf_wr_info = buf_wr_info_q;
endmodule

// [sfcs_host.sv]
// Purpose: spi host model driving the sequencer link
// Assumes: idle-high clock, 160 ns period
// Notes:   si flips after each frame so no stale bit lingers
`timescale 1ns/100ps
module sfcs_host (
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so
);
  logic [7:0] rx;
  // ==========================================================================
  // link idles with sck high and still outside frames
  initial begin
    cs_n = 1'b1;
    sck  = 1'b1;
    si   = 1'b0;
  end
  // one frame, msb first; the tail keeps cs_n high well past 300 ns
  task automatic frame(input logic [47:0] v, input int n);
    #37 cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      #80 sck = 1'b0;
      si = v[i];
      #80 sck = 1'b1;
      rx = {rx[6:0], so};
    end
    #80 cs_n = 1'b1;
    si = ~si;
    #400;
  endtask
endmodule

// [sfcs_seq_chk.sv]
// Purpose: port checks for the array command sequencer
// Assumes: wp_n steady around array commands
// Notes:   busy length is counted, not unrolled
`timescale 1ns/100ps
module sfcs_seq_chk
  import sfcs_pkg::*;
#(
  parameter int         EP_CYCLES  = ERASE_PROGRAM_CYCLES,
  parameter int         XFR_CYCLES = PAGE_TRANSFER_CYCLES,
  parameter logic [3:0] DENSITY    = DENSITY_DFLT  // arbitrary value
) (
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       cs_n,
  input wire logic       wp_n,
  input wire logic       arr_cmp_diff,
  input wire logic       so_oe,
  input wire logic       rdy_busy_oe,
  input wire logic [7:0] status_byte,
  input wire logic       spi_mode3,
  input wire logic       arr_start,
  input wire sfcs_areq_t arr_req,
  input wire logic       buf_wr
);
  int   len_q;
  logic long_q;
  logic cmp_q;
  // ==========================================================================
  // busy spell length; a second start inside one spell is a rewrite, which runs long
  always_ff @(posedge mclk) begin
    len_q <= (rstn && rdy_busy_oe) ? len_q + 1 : 0;
    if (arr_start) begin
      long_q <= (len_q != 0) || !(arr_req.op inside {AOP_XFR, AOP_CMP});
      cmp_q  <= arr_req.op == AOP_CMP;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_rst2;
    !rstn ##1 !rstn;
  endsequence
  sequence s_cmp_end;
    $fell(rdy_busy_oe) && cmp_q;
  endsequence
  AST_LEN: assert property ($fell(rdy_busy_oe) |-> len_q == (long_q ? EP_CYCLES : XFR_CYCLES))
    else $error("busy spell has the wrong length");
  AST_START_BUSY: assert property (arr_start |-> rdy_busy_oe)
    else $error("start without busy");
  AST_START_PULSE: assert property (arr_start |=> !arr_start)
    else $error("start longer than one cycle");
  AST_READY: assert property (1'b1 |=> status_byte[ST_READY_BIT] == !$past(rdy_busy_oe))
    else $error("ready bit does not follow busy");
  AST_COMP: assert property (s_cmp_end |-> ##2 status_byte[ST_COMP_BIT] == $past(arr_cmp_diff, 3))
    else $error("compare bit wrong");
  AST_BLOCK: assert property (arr_start && arr_req.op == AOP_BLOCK_ERASE |-> arr_req.page_addr[2:0] == 3'h0)
    else $error("block erase not aligned");
  AST_PROTECT: assert property (arr_start && !(arr_req.op inside {AOP_XFR, AOP_CMP}) && !wp_n && $past(wp_n, 4) == 1'b0
                                |-> arr_req.page_addr[11:8] != WP_PAGE_HI)
    else $error("protected page changed");
  AST_SO_OFF: assert property (cs_n |-> !so_oe)
    else $error("so driven while deselected");
  AST_BYTE: assert property (buf_wr |=> !buf_wr)
    else $error("buffer write longer than one cycle");
  AST_RESET: assert property (disable iff (1'b0) s_rst2 |=> !rdy_busy_oe && !arr_start && spi_mode3
                              && status_byte[7:2] == {2'b10, DENSITY})
    else $error("reset state wrong");
endmodule

bind sfcs_seq sfcs_seq_chk #(.EP_CYCLES(EP_CYCLES), .XFR_CYCLES(XFR_CYCLES), .DENSITY(DENSITY)) u_chk (
  .mclk, .rstn, .cs_n, .wp_n, .arr_cmp_diff, .so_oe, .rdy_busy_oe, .status_byte, .spi_mode3,
  .arr_start, .arr_req, .buf_wr);

// [sfcs_seq_bench.sv]
// Purpose: self-checking bench for the array command sequencer
// Assumes: shortened self-timed counts
// Notes:   array is reduced to the compare flag
`timescale 1ns/100ps
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; $display("unexpected %s exp %h got %h", nm, e, a); end end
module sfcs_seq_bench;
  import sfcs_pkg::*;
  localparam int EP = 300;
  localparam int XF = 10;
  logic       mclk, rstn, wp_n, diff, so, so_oe, rdy, rdy_oe, m3, go, bwr, cs_n, sck, si;
  logic [7:0] stat;
  sfcs_areq_t req;
  sfcs_bwr_t  bwi;
  sfcs_areq_t aq[$];
  sfcs_bwr_t  bq[$];
  int         n_mismatch, cmp_count, blen;
  wire        so_w = so_oe ? so : ~so;   // released line never shows the last bit
  wire        rb_w = rdy_oe ? rdy : 1'b1;  // external pull-up
  sfcs_seq #(.EP_CYCLES(EP), .XFR_CYCLES(XF), .DENSITY(DENSITY_DFLT)) u_dut (
    .mclk, .rstn, .sck, .cs_n, .si, .wp_n, .arr_cmp_diff(diff), .so, .so_oe, .rdy_busy(rdy),
    .rdy_busy_oe(rdy_oe), .status_byte(stat), .spi_mode3(m3), .arr_start(go), .arr_req(req),
    .buf_wr(bwr), .buf_wr_info(bwi));
  sfcs_host u_host (.cs_n, .sck, .si, .so(so_w));
  // ==========================================================================
  // clock and monitors of starts, buffer writes and busy cycles
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (go) aq.push_back(req);
    if (bwr) bq.push_back(bwi);
    if (rdy_oe) blen++;
  end
  task automatic idle();
    repeat (2) @(negedge mclk);
    for (int t = 0; t < 400 && rdy_oe; t++) @(negedge mclk);
    repeat (3) @(negedge mclk);
  endtask
  // one array command; ns starts expected, eo the last op, len busy cycles
  task automatic run(input logic [7:0] op, input logic [11:0] pg, input sfcs_aop_t eo,
                     input logic eb, input int ns, input int len);
    logic [47:0] v;
    aq.delete();
    bq.delete();
    blen = 0;
    v = {op, 3'h0, pg, 9'h107, 16'ha55a};
    // the host sends the low n bits, so header-only frames drop the data tail
    u_host.frame((op == 8'h82) ? v : (v >> 16), (op == 8'h82) ? 48 : 32);
    idle();
    `CHK("mode", 1'b1, m3)
    `CHK("busy len", len, blen)
    `CHK("starts", ns, aq.size())
    `CHK("ready", 1'b1, stat[7])
    `CHK("pin", 1'b1, rb_w)
    if (ns > 0) begin
      `CHK("op", eo, aq[ns-1].op)
      `CHK("buf", eb, aq[0].buf_sel)
      `CHK("page", (eo == AOP_BLOCK_ERASE) ? {pg[11:3], 3'h0} : pg, aq[0].page_addr)
    end
  endtask
  // second buffer busy: other buffer and status stay usable, array refused
  task automatic t_busy();
    aq.delete();
    bq.delete();
    u_host.frame({16'h0086, 3'h0, 12'h200, 9'h0}, 32);
    u_host.frame({16'h0053, 24'h0}, 32);
    u_host.frame({8'h84, 15'h0, 9'h005, 8'h3c}, 40);
    u_host.frame({8'hd7, 8'h00}, 16);
    `CHK("busy bit", 1'b0, u_host.rx[7])
    `CHK("pin busy", 1'b0, rb_w)
    `CHK("other buf", {1'b0, 9'h005, 8'h3c}, bq[0])
    idle();
    `CHK("one start", 1, aq.size())
  endtask
  // reset in mid rewrite aborts at once
  task automatic t_abort();
    u_host.frame({16'h0058, 3'h0, 12'h300, 9'h0}, 32);
    @(negedge mclk);
    rstn = 1'b0;
    repeat (4) @(negedge mclk);
    `CHK("abort", 1'b0, rdy_oe)
    `CHK("abort rdy", 1'b1, stat[7])
    rstn = 1'b1;
    repeat (4) @(negedge mclk);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    rstn = 1'b0;
    wp_n = 1'b1;
    diff = 1'b0;
    repeat (4) @(negedge mclk);
    rstn = 1'b1;
    `CHK("mode", 1'b1, m3)
    `CHK("status", {2'b10, DENSITY_DFLT, 2'b00}, stat)
    repeat (4) @(negedge mclk);
    run(8'h53, 12'h123, AOP_XFR, 1'b0, 1, XF);
    run(8'h55, 12'hfff, AOP_XFR, 1'b1, 1, XF);
    diff = 1'b1;
    run(8'h60, 12'h001, AOP_CMP, 1'b0, 1, XF);
    `CHK("comp", 1'b1, stat[6])
    diff = 1'b0;
    run(8'h61, 12'h002, AOP_CMP, 1'b1, 1, XF);
    `CHK("comp", 1'b0, stat[6])
    run(8'h59, 12'h300, AOP_PROG_ERASE, 1'b1, 2, EP);
    run(8'h50, 12'hfff, AOP_BLOCK_ERASE, 1'b0, 1, EP);
    run(8'h82, 12'h400, AOP_PROG_ERASE, 1'b0, 1, EP);
    `CHK("bytes", 2, bq.size())
    `CHK("wrap", {1'b0, 9'h107, 8'ha5, 1'b0, 9'h000, 8'h5a}, {bq[0], bq[1]})
    wp_n = 1'b0;
    run(8'h83, 12'h0ff, AOP_PROG_ERASE, 1'b0, 0, 0);
    run(8'h81, 12'h100, AOP_PAGE_ERASE, 1'b0, 1, EP);
    wp_n = 1'b1;
    t_busy();
    t_abort();
    wrap_up();
  end
  initial begin
    #3000000;
    n_mismatch++;
    wrap_up();
  end
endmodule
